// ===== bench/rx_flow_control_tb.sv
// self-checking testbench for the receive flow control block
`timescale 1ns/1ps
module rx_flow_control_tb import rxfc_pkg::*; ;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, dtr_n, rx_data, rx_enable, sp_valid, sp_ready;
    logic [3:0] rx_fifo_level = 4'h0;
    logic rx_char_valid = 1'b0, tx_break = 1'b0, tx_flow_off = 1'b0;
    logic dsr_n_pin = 1'b1, rxd_pin = 1'b1, slow = 1'b0;
    logic [7:0] sp_char, got_count;
    logic [15:0] got_last2;
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] exp_cnt = 8'h00;
    logic [31:0] rd;
    logic err;
    logic [2:0] sel_tab [5] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h1};
    logic [7:0] chr_tab [5] = '{8'h11, 8'h33, 8'h22, 8'h44, 8'h11};
    logic [31:0] flg_tab [5] = '{32'h5, 32'h5, 32'h6, 32'h6, 32'h5};

    always #10 pclk = ~pclk;

    rxfc_top #(.FIFO_DEPTH(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_fifo_level(rx_fifo_level), .rx_char_valid(rx_char_valid), .tx_break(tx_break),
        .tx_flow_off(tx_flow_off), .sp_ready(sp_ready), .dsr_n_pin(dsr_n_pin), .rxd_pin(rxd_pin),
        .dtr_n(dtr_n), .rx_data(rx_data), .rx_enable(rx_enable), .sp_valid(sp_valid), .sp_char(sp_char));

    rxfc_remote_model remote_u (.pclk(pclk), .presetn(presetn), .slow(slow), .sp_valid(sp_valid),
        .sp_char(sp_char), .sp_ready(sp_ready), .got_count(got_count), .got_last2(got_last2));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("apb pready", {31'h0, pready}, 32'h1);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic dtr_chk(input logic [3:0] lvl, input logic exp);
        rx_fifo_level <= lvl;
        repeat (3) @(posedge pclk);
        check("dtr_n", {31'h0, dtr_n}, {31'h0, exp});
    endtask

    task automatic send_sp(input logic [2:0] sel, input logic [7:0] nch);
        int n = 0;
        do begin
            apb(1'b0, RXFC_CMD_OFF, 32'h0);
            n++;
        end while (rd !== 32'h0 && n < 20);
        check("cmd idle", rd, 32'h0);
        apb(1'b1, RXFC_CMD_OFF, 32'h20 | {29'h0, sel});
        exp_cnt = exp_cnt + nch;
    endtask

    task automatic wait_got();
        int n = 0;
        while (got_count !== exp_cnt && n < 200) begin
            @(posedge pclk);
            n++;
        end
        check("sent count", {24'h0, got_count}, {24'h0, exp_cnt});
    endtask

    initial begin
        #400000;
        fail_count++;
        $display("BAD watchdog expected done seen timeout");
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("dtr_n reset", {31'h0, dtr_n}, 32'h1);
        check("rx_data reset", {31'h0, rx_data}, 32'h1);
        check("sp_valid reset", {31'h0, sp_valid}, 32'h0);
        rd_chk("cmd", RXFC_CMD_OFF, 32'h0);
        rd_chk("mco", RXFC_MCO_OFF, 32'h0);
        rd_chk("co3", RXFC_CO3_OFF, 32'h1);
        rd_chk("sch", RXFC_SCH_OFF, 32'h0);
        rd_chk("ctl", RXFC_CTL_OFF, 32'h0);
        apb(1'b1, RXFC_CSR_OFF, 32'hffffffff);
        rd_chk("csr", RXFC_CSR_OFF, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test registers done");
        apb(1'b1, RXFC_MCO_OFF, 32'h100);
        dtr_chk(4'h8, 1'b0);
        apb(1'b1, RXFC_MCO_OFF, 32'h0);
        dtr_chk(4'h8, 1'b1);
        apb(1'b1, RXFC_CTL_OFF, 32'h1);
        @(posedge pclk);
        check("rx_enable", {31'h0, rx_enable}, 32'h1);
        for (int t = 1; t <= 8; t++) begin
            apb(1'b1, RXFC_MCO_OFF, 32'h80 | t);
            dtr_chk(4'(t - 1), 1'b0);
            dtr_chk(4'(t), 1'b1);
        end
        apb(1'b1, RXFC_MCO_OFF, 32'h80);
        dtr_chk(4'h8, 1'b0);
        apb(1'b1, RXFC_CO3_OFF, 32'h5);
        apb(1'b1, RXFC_MCO_OFF, 32'h82);
        dtr_chk(4'h4, 1'b0);
        dtr_chk(4'h5, 1'b1);
        dtr_chk(4'h0, 1'b0);
        apb(1'b1, RXFC_CO3_OFF, 32'h1);
        apb(1'b1, RXFC_CTL_OFF, 32'h0);
        dtr_chk(4'h0, 1'b1);
        apb(1'b1, RXFC_CTL_OFF, 32'h3);
        dtr_chk(4'h0, 1'b1);
        $display("test ready output done");
        apb(1'b1, RXFC_SCH_OFF, 32'h44332211);
        tx_flow_off <= 1'b1;
        apb(1'b1, RXFC_CTL_OFF, 32'h0);
        rd_chk("csr txfl", RXFC_CSR_OFF, 32'h4);
        for (int i = 0; i < 5; i++) begin
            send_sp(sel_tab[i], 8'h01);
            wait_got();
            check("sent char", {24'h0, got_last2[7:0]}, {24'h0, chr_tab[i]});
            rd_chk("csr flags", RXFC_CSR_OFF, flg_tab[i]);
            rd_chk("cmd ack", RXFC_CMD_OFF, 32'h0);
        end
        @(posedge pclk);
        rx_char_valid <= 1'b1;
        @(posedge pclk);
        rx_char_valid <= 1'b0;
        rd_chk("csr rx", RXFC_CSR_OFF, 32'h4);
        tx_break <= 1'b1;
        send_sp(3'h2, 8'h01);
        repeat (40) @(posedge pclk);
        check("held in break", {31'h0, sp_valid}, 32'h0);
        tx_break <= 1'b0;
        wait_got();
        check("after break", {24'h0, got_last2[7:0]}, 32'h22);
        rd_chk("csr off", RXFC_CSR_OFF, 32'h6);
        apb(1'b1, RXFC_CMD_OFF, 32'h27);
        repeat (10) @(posedge pclk);
        rd_chk("cmd bad select", RXFC_CMD_OFF, 32'h0);
        check("no send count", {24'h0, got_count}, {24'h0, exp_cnt});
        rd_chk("csr unchanged", RXFC_CSR_OFF, 32'h6);
        $display("test single characters done");
        slow <= 1'b1;
        apb(1'b1, RXFC_CO3_OFF, 32'hc1);
        send_sp(3'h1, 8'h02);
        wait_got();
        check("resume pair", {16'h0, got_last2}, 32'h1133);
        rd_chk("csr on", RXFC_CSR_OFF, 32'h5);
        send_sp(3'h2, 8'h02);
        wait_got();
        check("pause pair", {16'h0, got_last2}, 32'h2244);
        slow <= 1'b0;
        $display("test pairs done");
        tx_flow_off <= 1'b0;
        apb(1'b1, RXFC_CTL_OFF, 32'h1);
        apb(1'b1, RXFC_CO2_OFF, 32'h1);
        rxd_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        check("rx gated", {31'h0, rx_data}, 32'h1);
        dsr_n_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        check("rx passes", {31'h0, rx_data}, 32'h0);
        apb(1'b1, RXFC_CO2_OFF, 32'h0);
        dsr_n_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        check("rx ungated", {31'h0, rx_data}, 32'h0);
        apb(1'b1, RXFC_CTL_OFF, 32'h3);
        rd_chk("csr chan reset", RXFC_CSR_OFF, 32'h8);
        rd_chk("cmd chan reset", RXFC_CMD_OFF, 32'h0);
        $display("test receive gating done");
        give_verdict();
    end
endmodule

// ===== bench/rxfc_remote_model.sv
// far end model: transmitter path that takes special characters, prompt or slow
`timescale 1ns/1ps
module rxfc_remote_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic sp_valid,
    input wire logic [7:0] sp_char,
    output logic sp_ready,
    output logic [7:0] got_count,
    output logic [15:0] got_last2
);
    logic [1:0] wait_q;

    // a character counts as sent only on valid and ready at one edge; slow mode stalls for a while
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_ready <= 1'b0;
            wait_q <= 2'h0;
            got_count <= 8'h00;
            got_last2 <= 16'h0000;
        end else if (sp_valid && sp_ready) begin
            sp_ready <= 1'b0;
            wait_q <= 2'h0;
            got_count <= got_count + 8'h01;
            got_last2 <= {got_last2[7:0], sp_char};
        end else if (sp_valid) begin
            wait_q <= wait_q + 2'h1;
            sp_ready <= !slow || (wait_q == 2'h2);
        end else begin
            sp_ready <= 1'b0;
            wait_q <= 2'h0;
        end
    end
endmodule

// ===== hw/rxfc_spch.sv
// special character sequencer, single or two character, waits out a break
`timescale 1ns/1ps
module rxfc_spch
    import rxfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    rxfc_sp_if.seq sp,
    input wire logic tx_break,
    input wire logic sp_ready,
    output logic sp_valid,
    output logic [7:0] sp_char
);
    rxfc_state_e state_q, state_d;
    logic [7:0] c1_d, c2_d, c2_q, char_q;
    logic two_d, two_q, xon_d, xon_q, xoff_d, xoff_q;
    logic valid_q, xon_sent_q, xoff_sent_q;
    logic take, finish;

    // select byte for the lower command bits
    assign c1_d = (sp.sel == RXFC_SEL_ONE) ? sp.chars[7:0] :
                  (sp.sel == RXFC_SEL_TWO) ? sp.chars[15:8] :
                  (sp.sel == RXFC_SEL_THREE) ? sp.chars[23:16] : sp.chars[31:24];
    // one with three resumes, two with four pauses
    assign two_d = ((sp.sel == RXFC_SEL_ONE) && sp.two_xon) || ((sp.sel == RXFC_SEL_TWO) && sp.two_xoff);
    assign c2_d = (sp.sel == RXFC_SEL_ONE) ? sp.chars[23:16] : sp.chars[31:24];
    assign xon_d = (sp.sel == RXFC_SEL_ONE);
    assign xoff_d = (sp.sel == RXFC_SEL_TWO);
    assign take = valid_q && sp_ready;
    assign finish = take && ((state_q == RXFC_ST_SECOND) || !two_q);

    // no transmit enable or transmit flow state is consulted here
    always_comb begin
        state_d = state_q;
        case (state_q)
            RXFC_ST_IDLE: if (sp.start) state_d = RXFC_ST_BRK;
            RXFC_ST_BRK: if (!tx_break) state_d = RXFC_ST_FIRST;
            RXFC_ST_FIRST: if (take) state_d = two_q ? RXFC_ST_SECOND : RXFC_ST_IDLE;
            RXFC_ST_SECOND: if (take) state_d = RXFC_ST_IDLE;
            default: state_d = RXFC_ST_IDLE;
        endcase
        if (sp.abort) state_d = RXFC_ST_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RXFC_ST_IDLE;
            char_q <= 8'h00;
            c2_q <= 8'h00;
            two_q <= 1'b0;
            xon_q <= 1'b0;
            xoff_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == RXFC_ST_IDLE && sp.start) begin
                char_q <= c1_d;
                c2_q <= c2_d;
                two_q <= two_d;
                xon_q <= xon_d;
                xoff_q <= xoff_d;
            end else if (state_q == RXFC_ST_FIRST && take) begin
                char_q <= c2_q;
            end
        end
    end

    // the character goes to the line ahead of queued data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
            xon_sent_q <= 1'b0;
            xoff_sent_q <= 1'b0;
        end else begin
            valid_q <= !sp.abort && (state_d == RXFC_ST_FIRST || state_d == RXFC_ST_SECOND);
            xon_sent_q <= !sp.abort && finish && xon_q;
            xoff_sent_q <= !sp.abort && finish && xoff_q;
        end
    end

    assign sp.idle = (state_q == RXFC_ST_IDLE);
    assign sp.xon_sent = xon_sent_q;
    assign sp.xoff_sent = xoff_sent_q;
    assign sp_valid = valid_q;
    assign sp_char = char_q;

    a_brk_wait: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(valid_q) |-> !$past(tx_break))
        else $error("special character started during a break");
    a_pair_second: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == RXFC_ST_FIRST && take && two_q && !sp.abort) |=> valid_q && char_q == $past(c2_q))
        else $error("second character of the pair not presented");
endmodule

// ===== hw/rxfc_sync.sv
// two flop synchroniser, one per bit
`timescale 1ns/1ps
module rxfc_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q <= INIT[i];
                    sync_q <= INIT[i];
                end else begin
                    meta_q <= d[i];
                    sync_q <= meta_q;
                end
            end
            assign q[i] = sync_q;
        end
    endgenerate
endmodule

// ===== hw/rxfc_top.sv
// receive flow control: threshold ready output, set ready gating, special characters
`timescale 1ns/1ps
// Notes on behaviour
// - negate ready output at fifo threshold
// - four bit threshold, one to eight, or off
// - auto mode negates ready when disabled or reset
// - manual mode leaves pin at host value
// - low threshold replaced by service threshold
// - discard receive data while set ready negated
// - keep receiving after sending flow off
// - low three command bits pick character
// - two character sequence for one or two
// - send ignores transmit enable and flow state
// - bypass transmit fifo, within two characters
// - wait for break end before sending
// - xoff sent clears on flag, sets off
// - xon sent clears off flag, sets on
// - received data clears flow on flag
// - fifo borne flow characters leave status alone
// - flag pair encodes last flow state
// - transmit flow status always readable
// - command register cleared on acceptance
// - pairs are one with three, two with four
module rxfc_top
    import rxfc_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = RXFC_FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [RXFC_ADDR_W-1:0] paddr,
    input wire logic [RXFC_DATA_W-1:0] pwdata,
    output logic [RXFC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [RXFC_LVL_W-1:0] rx_fifo_level,
    input wire logic rx_char_valid,
    input wire logic tx_break,
    input wire logic tx_flow_off,
    input wire logic sp_ready,
    input wire logic dsr_n_pin,
    input wire logic rxd_pin,
    output logic dtr_n,
    output logic rx_data,
    output logic rx_enable,
    output logic sp_valid,
    output logic [7:0] sp_char
);
    generate
        if (FIFO_DEPTH != RXFC_FIFO_DEPTH) begin : g_bad_depth
            $error("threshold logic serves a receive fifo of eight only");
        end
    endgenerate

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rxfc_sp_if sp_link ();

    logic [7:0] cmd_q, cmd_d;
    logic [8:0] mco_q;
    logic co2_q;
    logic [7:0] co3_q;
    logic [31:0] sch_q;
    logic [1:0] ctl_q;
    logic flon_q, flon_d, floff_q, floff_d;
    logic dtr_n_q, dtr_n_d, rx_data_q;
    logic [RXFC_DATA_W-1:0] prdata_q;
    logic [RXFC_DATA_W-1:0] rdata;
    logic pready_q, pslverr_q;
    logic dsr_s, rxd_s;

    wire access = psel && penable;
    wire wr_fire = access && pwrite && pready_q;
    wire hit_cmd = (paddr == RXFC_CMD_OFF);
    wire hit_mco = (paddr == RXFC_MCO_OFF);
    wire hit_co2 = (paddr == RXFC_CO2_OFF);
    wire hit_co3 = (paddr == RXFC_CO3_OFF);
    wire hit_csr = (paddr == RXFC_CSR_OFF);
    wire hit_sch = (paddr == RXFC_SCH_OFF);
    wire hit_ctl = (paddr == RXFC_CTL_OFF);
    wire mapped = hit_cmd || hit_mco || hit_co2 || hit_co3 || hit_csr || hit_sch || hit_ctl;

    wire chan_en = ctl_q[RXFC_CTL_EN_BIT];
    wire chan_rst = ctl_q[RXFC_CTL_RST_BIT];
    wire auto_mode = mco_q[RXFC_MCO_AUTO_BIT];
    wire host_dtr = mco_q[RXFC_MCO_DTR_BIT];
    wire [3:0] dtr_thr = mco_q[RXFC_MCO_THR_LSB +: 4];
    wire [3:0] srv_thr = co3_q[RXFC_CO3_SRV_LSB +: 4];
    wire dsr_auto = co2_q;

    // synchronise the pins before anything reads them
    rxfc_sync #(
        .W(2),
        .INIT(2'h3)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({dsr_n_pin, rxd_pin}),
        .q({dsr_s, rxd_s})
    );

    // register read mux
    always_comb begin
        rdata = '0;
        if (hit_cmd) begin
            rdata[7:0] = cmd_q;
        end else if (hit_mco) begin
            rdata[8:0] = mco_q;
        end else if (hit_co2) begin
            rdata[RXFC_CO2_SET_READY_AUTO_ENABLE_BIT] = co2_q;
        end else if (hit_co3) begin
            rdata[7:0] = co3_q;
        end else if (hit_csr) begin
            rdata[RXFC_CSR_FLON_BIT] = flon_q;
            rdata[RXFC_CSR_FLOFF_BIT] = floff_q;
            rdata[RXFC_CSR_TXFL_BIT] = tx_flow_off;
            rdata[RXFC_CSR_EN_BIT] = chan_en;
        end else if (hit_sch) begin
            rdata = sch_q;
        end else if (hit_ctl) begin
            rdata[1:0] = ctl_q;
        end
    end

    // one wait state on every access, error for unmapped addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= access && !pready_q;
            pslverr_q <= access && !pready_q && !mapped;
            if (access && !pready_q && !pwrite) begin
                prdata_q <= rdata;
            end
        end
    end

    // option and control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mco_q <= RXFC_MCO_RST;
            co2_q <= 1'b0;
            co3_q <= RXFC_CO3_RST;
            sch_q <= RXFC_SCH_RST;
            ctl_q <= RXFC_CTL_RST;
        end else if (wr_fire) begin
            if (hit_mco) begin
                mco_q <= pwdata[8:0];
            end else if (hit_co2) begin
                co2_q <= pwdata[RXFC_CO2_SET_READY_AUTO_ENABLE_BIT];
            end else if (hit_co3) begin
                co3_q <= pwdata[7:0];
            end else if (hit_sch) begin
                sch_q <= pwdata;
            end else if (hit_ctl) begin
                ctl_q <= pwdata[1:0];
            end
        end
    end

    // command register: accepted when the sequencer is idle, then cleared
    wire cmd_take = (cmd_q != 8'h00) && sp_link.idle && !chan_rst;
    wire [2:0] cmd_sel = cmd_q[RXFC_CMD_SEL_LSB +: 3];
    wire sel_ok = (cmd_sel >= RXFC_SEL_ONE) && (cmd_sel <= RXFC_SEL_FOUR);
    // a write while still non-zero is dropped
    wire cmd_wr = wr_fire && hit_cmd && (cmd_q == 8'h00);
    assign cmd_d = chan_rst ? RXFC_CMD_RST : cmd_take ? RXFC_CMD_RST : cmd_wr ? pwdata[7:0] : cmd_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= RXFC_CMD_RST;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    assign sp_link.start = cmd_take && cmd_q[RXFC_CMD_SEND_BIT] && sel_ok;
    assign sp_link.abort = chan_rst;
    assign sp_link.sel = cmd_sel;
    assign sp_link.two_xon = co3_q[RXFC_CO3_RESUME2_BIT];
    assign sp_link.two_xoff = co3_q[RXFC_CO3_PAUSE2_BIT];
    assign sp_link.chars = sch_q;

    rxfc_spch u_spch (
        .pclk(pclk),
        .presetn(presetn),
        .sp(sp_link.seq),
        .tx_break(tx_break),
        .sp_ready(sp_ready),
        .sp_valid(sp_valid),
        .sp_char(sp_char)
    );

    // flow flags change only on sequencer events, received data and channel reset
    // a flag set wins over a clear by received data in the same cycle; channel reset wins over a set
    assign flon_d = chan_rst ? 1'b0 : sp_link.xon_sent ? 1'b1 : sp_link.xoff_sent ? 1'b0 :
                    rx_char_valid ? 1'b0 : flon_q;
    assign floff_d = chan_rst ? 1'b0 : sp_link.xoff_sent ? 1'b1 : sp_link.xon_sent ? 1'b0 : floff_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flon_q <= 1'b0;
            floff_q <= 1'b0;
        end else begin
            flon_q <= flon_d;
            floff_q <= floff_d;
        end
    end

    // ready output threshold: the service threshold is the floor
    wire thr_on = (dtr_thr != 4'h0) && (dtr_thr <= 4'(FIFO_DEPTH));
    wire [3:0] thr_act = (dtr_thr < srv_thr) ? srv_thr : dtr_thr;
    wire thr_hit = thr_on && (rx_fifo_level >= thr_act);
    wire auto_neg = !chan_en || chan_rst || thr_hit;
    assign dtr_n_d = auto_mode ? auto_neg : !host_dtr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtr_n_q <= 1'b1;
            rx_data_q <= 1'b1;
        end else begin
            dtr_n_q <= dtr_n_d;
            // mark idle replaces line data while set ready is negated
            // flow flags never gate the receive path
            rx_data_q <= (dsr_auto && dsr_s) ? 1'b1 : rxd_s;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dtr_n = dtr_n_q;
    assign rx_data = rx_data_q;
    assign rx_enable = chan_en;

    a_dtr_thresh: assert property (
        auto_mode && chan_en && !chan_rst && thr_on && rx_fifo_level >= dtr_thr && rx_fifo_level >= srv_thr
        |=> dtr_n)
        else $error("ready output not negated at threshold");
    a_dtr_floor: assert property (
        auto_mode && chan_en && !chan_rst && thr_on && dtr_thr < srv_thr && rx_fifo_level < srv_thr
        |=> !dtr_n)
        else $error("low threshold not replaced by service threshold");
    a_dtr_down: assert property (
        auto_mode && (!chan_en || chan_rst) |=> dtr_n)
        else $error("ready output asserted while channel off");
    a_dtr_manual: assert property (
        !auto_mode |=> dtr_n == !$past(host_dtr))
        else $error("ready output moved in manual mode");
    a_dsr_discard: assert property (
        dsr_auto && dsr_s |=> rx_data)
        else $error("data passed while set ready negated");
    a_xoff_flags: assert property (
        sp_link.xoff_sent && !chan_rst |=> floff_q && !flon_q)
        else $error("flags wrong after flow off sent");
    a_xon_flags: assert property (
        sp_link.xon_sent && !chan_rst |=> flon_q && !floff_q)
        else $error("flags wrong after flow on sent");
    a_data_clear: assert property (
        rx_char_valid && !sp_link.xon_sent |=> !flon_q)
        else $error("flow on flag survived received data");
    a_flag_legal: assert property (
        !(flon_q && floff_q))
        else $error("illegal flow flag pair");
    a_cmd_ack: assert property (
        cmd_q != 8'h00 && sp_link.idle |=> cmd_q == 8'h00)
        else $error("accepted command not cleared");
    a_chan_reset: assert property (
        chan_rst |=> !flon_q && !floff_q && cmd_q == 8'h00 && sp_link.idle)
        else $error("channel reset left flags or command");
endmodule

// ===== pkg/rxfc_pkg.sv
// constants, field positions and types shared by the receive flow control block
package rxfc_pkg;

    localparam int unsigned RXFC_ADDR_W = 8;
    localparam int unsigned RXFC_DATA_W = 32;
    localparam int unsigned RXFC_LVL_W = 4;
    localparam int unsigned RXFC_FIFO_DEPTH = 8;

    localparam logic [7:0] RXFC_CMD_OFF = 8'h00;
    localparam logic [7:0] RXFC_MCO_OFF = 8'h04;
    localparam logic [7:0] RXFC_CO2_OFF = 8'h08;
    localparam logic [7:0] RXFC_CO3_OFF = 8'h0c;
    localparam logic [7:0] RXFC_CSR_OFF = 8'h10;
    localparam logic [7:0] RXFC_SCH_OFF = 8'h14;
    localparam logic [7:0] RXFC_CTL_OFF = 8'h18;

    localparam int unsigned RXFC_CMD_SEL_LSB = 0;
    localparam int unsigned RXFC_CMD_SEND_BIT = 5;
    localparam int unsigned RXFC_MCO_THR_LSB = 0;
    localparam int unsigned RXFC_MCO_AUTO_BIT = 7;
    localparam int unsigned RXFC_MCO_DTR_BIT = 8;
    localparam int unsigned RXFC_CO2_SET_READY_AUTO_ENABLE_BIT = 0;
    localparam int unsigned RXFC_CO3_SRV_LSB = 0;
    localparam int unsigned RXFC_CO3_PAUSE2_BIT = 6;
    localparam int unsigned RXFC_CO3_RESUME2_BIT = 7;
    localparam int unsigned RXFC_CSR_FLON_BIT = 0;
    localparam int unsigned RXFC_CSR_FLOFF_BIT = 1;
    localparam int unsigned RXFC_CSR_TXFL_BIT = 2;
    localparam int unsigned RXFC_CSR_EN_BIT = 3;
    localparam int unsigned RXFC_CTL_EN_BIT = 0;
    localparam int unsigned RXFC_CTL_RST_BIT = 1;

    localparam logic [7:0] RXFC_CMD_RST = 8'h00;
    localparam logic [8:0] RXFC_MCO_RST = 9'h000;
    localparam logic [7:0] RXFC_CO3_RST = 8'h01;
    localparam logic [31:0] RXFC_SCH_RST = 32'h00000000;
    localparam logic [1:0] RXFC_CTL_RST = 2'h0;

    localparam logic [2:0] RXFC_SEL_ONE = 3'h1;
    localparam logic [2:0] RXFC_SEL_TWO = 3'h2;
    localparam logic [2:0] RXFC_SEL_THREE = 3'h3;
    localparam logic [2:0] RXFC_SEL_FOUR = 3'h4;

    typedef enum logic [3:0] {
        RXFC_ST_IDLE = 4'b0001,
        RXFC_ST_BRK = 4'b0010,
        RXFC_ST_FIRST = 4'b0100,
        RXFC_ST_SECOND = 4'b1000
    } rxfc_state_e;

endpackage

// ===== pkg/rxfc_sp_if.sv
// link between register logic and the special character sequencer
`timescale 1ns/1ps
interface rxfc_sp_if;
    logic start;
    logic abort;
    logic [2:0] sel;
    logic two_xon;
    logic two_xoff;
    logic [31:0] chars;
    logic idle;
    logic xon_sent;
    logic xoff_sent;

    modport ctl (
        output start,
        output abort,
        output sel,
        output two_xon,
        output two_xoff,
        output chars,
        input idle,
        input xon_sent,
        input xoff_sent
    );

    modport seq (
        input start,
        input abort,
        input sel,
        input two_xon,
        input two_xoff,
        input chars,
        output idle,
        output xon_sent,
        output xoff_sent
    );
endinterface
